/* rtl/sdl_consts.vh */
// field positions, reset values and timing counts of the synthesizer load path
`ifndef SDL_CONSTS_VH
`define SDL_CONSTS_VH

// serial word
`define SDL_WORD_BITS      19
`define SDL_TARGET_BIT     0
`define SDL_TARGET_REF     1'b1
`define SDL_TARGET_PROG    1'b0

// reference word fields
`define SDL_REF_PRE_BIT    18
`define SDL_REF_CS_BIT     17
`define SDL_REF_LDS_BIT    16
`define SDL_REF_FC_BIT     15
`define SDL_REF_R_MSB      14
`define SDL_REF_R_LSB      1

// programmable word fields
`define SDL_PROG_N_MSB     18
`define SDL_PROG_N_LSB     8
`define SDL_PROG_A_MSB     7
`define SDL_PROG_A_LSB     1

// divider limits
`define SDL_R_MIN          14'h0003
`define SDL_N_MIN          11'h003

// reset values
`define SDL_R_RESET        14'h0003
`define SDL_N_RESET        11'h003
`define SDL_A_RESET        7'h00

// timing
`define SDL_CLK_HZ         125000000
`define SDL_CLK_PER_US     (`SDL_CLK_HZ / 1000000)
`define SDL_LOCK_TIME_US   30000
`define SDL_LOCK_CYCLES    (`SDL_LOCK_TIME_US * `SDL_CLK_PER_US)
`define SDL_PULSE_MIN_US   100
`define SDL_PULSE_MIN_CYC  (`SDL_PULSE_MIN_US * `SDL_CLK_PER_US)
`define SDL_PULSE_MAX_MS   15
`define SDL_PULSE_MAX_CYC  (`SDL_PULSE_MAX_MS * 1000 * `SDL_CLK_PER_US)

`endif

/* rtl/sdl_lock_monitor.v */
// lock settle timer: reports lock once new dividers have settled and are legal
`timescale 1ns/1ps
`include "sdl_consts.vh"

module sdl_lock_monitor #(
    parameter LOCK_CYCLES = `SDL_LOCK_CYCLES,
    parameter CNT_W       = 23
) (
    input  wire              clk,
    input  wire              rstSync_n,
    input  wire              newLoad,
    input  wire              settingsValid,
    output reg               locked_q
);

    reg  [CNT_W-1:0] settle_q;
    wire             settleDone;

    assign settleDone = (settle_q == LOCK_CYCLES[CNT_W-1:0]);

    // any load drops lock and restarts the settle wait
    always @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            settle_q <= {CNT_W{1'b0}};
            locked_q <= 1'b0;
        end else if (newLoad) begin
            settle_q <= {CNT_W{1'b0}};
            locked_q <= 1'b0;                                   // [R03]
        end else begin
            if (!settleDone) begin
                settle_q <= settle_q + {{(CNT_W-1){1'b0}}, 1'b1};
            end
            // illegal dividers never lock
            locked_q <= settleDone & settingsValid;             // [R03]
        end
    end

endmodule // sdl_lock_monitor

/* rtl/sdl_serial_load.v */
// synthesizer divider serial load, lock report and tx/rx select
// Behaviour
// R01 - transmit-select low, receive-select high enables the transmitter.
// R02 - receive-select low, transmit-select high enables the receiver.
// R03 - lock-detect high while locked, low while unlocked.
// R04 - host keeps tx data pulses between 100 us and 15 ms.
// R05 - host programs oscillator to channel minus 21.7 MHz.
// R06 - host picks 6.25/12.5/25 kHz comparison; reference divider from 21.25 MHz.
// R07 - reference divider is 14-bit, 3 to 16383.
// R08 - main divider is 11-bit, 3 to 2047.
// R09 - swallow divider 7-bit, 0 to 127, below main divider.
// R10 - prescaler ratio is 64 or 128.
// R11 - host splits total count into main quotient and swallow remainder.
// R12 - host sends operation bits ahead of the reference divider.
// R13 - host sends charge-pump select as 0.
// R14 - host sends lock-output select as 0 for lock-detect.
// R15 - host sends table dividers on every channel change.
// R16 - dividers arrive serially on data, framed by serial clock and load strobe.
// R17 - data sampled on each serial clock rising edge.
// R18 - host holds load strobe low while shifting.
// R19 - 19 bits collected; load strobe moves them to latch by trailing bit.
// R20 - host changes channel only in receive mode.
// R21 - host never drives both selects low together.
// R22 - host shifts msb first, latch-target bit last.
`timescale 1ns/1ps
`include "sdl_consts.vh"

module sdl_serial_load #(
    parameter LOCK_CYCLES   = `SDL_LOCK_CYCLES,
    parameter PULSE_MIN_CYC = `SDL_PULSE_MIN_CYC,
    parameter PULSE_MAX_CYC = `SDL_PULSE_MAX_CYC,
    parameter CNT_W         = 23
) (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        transmit_select_n,
    input  wire        receive_select_n,
    input  wire        serialClk,
    input  wire        serialData,
    input  wire        load_strobe,
    input  wire        tx_data_in,
    output wire        lock_detect,
    output reg         txActive_q,
    output reg         rxActive_q,
    output reg         txModData_q,
    output reg  [13:0] refDivider_q,
    output reg  [10:0] progDivider_q,
    output reg  [6:0]  swallowDivider_q,
    output reg         prescaler128_q,
    output reg         chargePumpHigh_q,
    output reg         lock_out_select_q,
    output reg         phasePolarity_q,
    output reg         pulseWidthErr_q,
    output reg         loadInTxErr_q
);

    reg  [1:0]                   rstPipe_q;
    wire                         rstSync_n;
    reg                          sclkPrev_q;
    reg                          strobePrev_q;
    reg  [`SDL_WORD_BITS-1:0]    shift_q;
    wire                         sclkRise;
    wire                         strobeRise;
    wire                         settingsValid;
    wire                         locked;
    reg  [13:0]                  refCount_q;
    reg                          fout_q;
    reg                          lockOut_q;
    reg                          txPrev_q;
    reg  [CNT_W-1:0]             pulseLen_q;

    // rising edge of a synchronous pin against its sample one clock back
    function riseOf;
        input pinNow;
        input pinPrev;
        begin
            riseOf = pinNow & ~pinPrev;
        end
    endfunction

    // reset release through two flops
    // assertion is immediate; release waits two clocks so no flop sees a runt
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstPipe_q <= 2'b00;
        end else begin
            rstPipe_q <= {rstPipe_q[0], 1'b1};
        end
    end
    assign rstSync_n = rstPipe_q[1];

    // serial pins are synchronous, so plain edge compare suffices
    assign sclkRise   = riseOf(serialClk, sclkPrev_q);          // [R17]
    assign strobeRise = riseOf(load_strobe, strobePrev_q);      // [R19]

    // shift msb first while strobe is low; a strobe-high clock edge is ignored
    // bits beyond nineteen push the oldest out; only the last nineteen count
    always @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            sclkPrev_q   <= 1'b0;
            strobePrev_q <= 1'b0;
            shift_q      <= {`SDL_WORD_BITS{1'b0}};
        end else begin
            sclkPrev_q   <= serialClk;
            strobePrev_q <= load_strobe;
            if (sclkRise && !load_strobe) begin                 // [R16] [R18]
                shift_q <= {shift_q[`SDL_WORD_BITS-2:0], serialData}; // [R17] [R22]
            end
        end
    end

    // word layout, first bit on the wire at the top:
    //   reference:    [18] prescaler 128, [17] charge pump, [16] lock-out select,
    //                 [15] phase control, [14:1] reference divider, [0] = 1
    //   programmable: [18:8] main divider, [7:1] swallow divider, [0] = 0
    // frames of the wrong length are not refused; they land misaligned, so the
    // host must send exactly nineteen bits between strobes
    // both latches start from legal minimum dividers, so reset alone can lock
    // strobe edge copies the word to the latch chosen by the trailing bit
    always @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            refDivider_q      <= `SDL_R_RESET;
            progDivider_q     <= `SDL_N_RESET;
            swallowDivider_q  <= `SDL_A_RESET;
            prescaler128_q    <= 1'b0;
            chargePumpHigh_q  <= 1'b0;
            lock_out_select_q <= 1'b0;
            phasePolarity_q   <= 1'b1;
        end else begin
            if (strobeRise) begin                               // [R19]
                if (shift_q[`SDL_TARGET_BIT] == `SDL_TARGET_REF) begin
                    refDivider_q      <= shift_q[`SDL_REF_R_MSB:`SDL_REF_R_LSB]; // [R07]
                    prescaler128_q    <= shift_q[`SDL_REF_PRE_BIT];           // [R10]
                    chargePumpHigh_q  <= shift_q[`SDL_REF_CS_BIT];
                    lock_out_select_q <= shift_q[`SDL_REF_LDS_BIT];
                    phasePolarity_q   <= shift_q[`SDL_REF_FC_BIT];
                end else begin
                    progDivider_q    <= shift_q[`SDL_PROG_N_MSB:`SDL_PROG_N_LSB]; // [R08]
                    swallowDivider_q <= shift_q[`SDL_PROG_A_MSB:`SDL_PROG_A_LSB]; // [R09]
                end
            end
        end
    end

    // legal settings only: lower bounds and swallow below main
    assign settingsValid = (refDivider_q >= `SDL_R_MIN)          // [R07]
                         & (progDivider_q >= `SDL_N_MIN)         // [R08]
                         & ({4'h0, swallowDivider_q} < progDivider_q); // [R09]

    // the load edge itself clears lock, so settling starts with the new dividers
    sdl_lock_monitor #(
        .LOCK_CYCLES   (LOCK_CYCLES),
        .CNT_W         (CNT_W)
    ) u_lock (
        .clk           (clk),
        .rstSync_n     (rstSync_n),
        .newLoad       (strobeRise),
        .settingsValid (settingsValid),
        .locked_q      (locked)
    );

    // divided reference for the shared pin when lock output is deselected
    // limitation: models the reference rate only, not the real divider phase
    always @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            refCount_q <= 14'h0000;
            fout_q     <= 1'b0;
            lockOut_q  <= 1'b0;
        end else begin
            if (refCount_q >= refDivider_q - 14'h0001) begin
                refCount_q <= 14'h0000;
                fout_q     <= ~fout_q;
            end else begin
                refCount_q <= refCount_q + 14'h0001;
            end
            // a load masks lock in its own cycle, so the pin never shows lock
            // for dividers that were replaced one clock after settling
            lockOut_q <= lock_out_select_q ? fout_q : (locked & ~strobeRise); // [R03] [R14]
        end
    end
    assign lock_detect = lockOut_q;

    // select decode; both low enables neither path
    // registered, so the radio paths follow the pins one clock late
    always @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            txActive_q    <= 1'b0;
            rxActive_q    <= 1'b0;
            txModData_q   <= 1'b0;
            loadInTxErr_q <= 1'b0;
        end else begin
            txActive_q    <= ~transmit_select_n & receive_select_n;  // [R01] [R21]
            rxActive_q    <= ~receive_select_n & transmit_select_n;  // [R02] [R21]
            txModData_q   <= txActive_q & tx_data_in;
            // a channel load while transmitting would splatter
            loadInTxErr_q <= strobeRise & txActive_q;                // [R20]
        end
    end

    // pulse width watch on the modulation input, transmit only
    // a run cut short by leaving transmit is dropped unjudged
    always @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            txPrev_q        <= 1'b0;
            pulseLen_q      <= {CNT_W{1'b0}};
            pulseWidthErr_q <= 1'b0;
        end else begin
            txPrev_q        <= tx_data_in;
            pulseWidthErr_q <= 1'b0;
            if (!txActive_q) begin
                pulseLen_q <= {CNT_W{1'b0}};
            end else if (tx_data_in != txPrev_q) begin
                // an edge in the first transmit cycle has a zero count and is not flagged; a later first edge judges the time since entry
                pulseWidthErr_q <= (pulseLen_q != {CNT_W{1'b0}})
                                 & (pulseLen_q < PULSE_MIN_CYC[CNT_W-1:0]);  // [R04]
                pulseLen_q      <= {{(CNT_W-1){1'b0}}, 1'b1};
            end else if (pulseLen_q != {CNT_W{1'b1}}) begin
                pulseLen_q      <= pulseLen_q + {{(CNT_W-1){1'b0}}, 1'b1};
                pulseWidthErr_q <= (pulseLen_q == PULSE_MAX_CYC[CNT_W-1:0]); // [R04]
            end
        end
    end

endmodule // sdl_serial_load

/* sim/sdl_checker.sv */
// concurrent checks on the synthesizer serial load ports
`timescale 1ns/1ps
module sdl_checker (
    input logic        clk,
    input logic        rst_n,
    input logic        transmit_select_n,
    input logic        receive_select_n,
    input logic        load_strobe,
    input logic        lock_detect,
    input logic        txActive_q,
    input logic        rxActive_q,
    input logic        txModData_q,
    input logic [13:0] refDivider_q,
    input logic [10:0] progDivider_q,
    input logic [6:0]  swallowDivider_q,
    input logic        lock_out_select_q,
    input logic        pulseWidthErr_q,
    input logic        loadInTxErr_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // strobe low then high marks a latch transfer
    sequence s_load_rise; !load_strobe ##1 load_strobe; endsequence
    property p_tx_sel; !transmit_select_n && receive_select_n |=> txActive_q && !rxActive_q;
    endproperty
    a_tx_sel: assert property (p_tx_sel) else $error("tx select not honoured");
    property p_rx_sel; !receive_select_n && transmit_select_n |=> rxActive_q && !txActive_q;
    endproperty
    a_rx_sel: assert property (p_rx_sel) else $error("rx select not honoured");
    property p_both_low; !transmit_select_n && !receive_select_n |=> !txActive_q && !rxActive_q;
    endproperty
    a_both_low: assert property (p_both_low) else $error("both paths enabled");
    property p_mod_gate; !txActive_q [*2] |-> !txModData_q; endproperty
    a_mod_gate: assert property (p_mod_gate) else $error("mod data leaks in rx");
    property p_lock_drop; s_load_rise ##0 !lock_out_select_q |-> ##[1:4] !lock_detect; endproperty
    a_lock_drop: assert property (p_lock_drop) else $error("lock kept over load");
    // lock may only appear on settings that can really lock
    property p_lock_legal; $rose(lock_detect) && !lock_out_select_q |-> refDivider_q >= 14'h0003
        && progDivider_q >= 11'h003 && {4'h0, swallowDivider_q} < progDivider_q; endproperty
    a_lock_legal: assert property (p_lock_legal) else $error("lock on bad dividers");
    property p_latch_hold; !load_strobe [*4] |=> $stable(refDivider_q)
        && $stable(progDivider_q) && $stable(swallowDivider_q); endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch moved unloaded");
    property p_pulse_once; pulseWidthErr_q |-> $past(txActive_q) ##1 !pulseWidthErr_q;
    endproperty
    a_pulse_once: assert property (p_pulse_once) else $error("bad width flag");
    property p_load_tx; s_load_rise ##0 txActive_q |-> ##[1:3] loadInTxErr_q; endproperty
    a_load_tx: assert property (p_load_tx) else $error("tx load not flagged");
endmodule // sdl_checker

bind sdl_serial_load sdl_checker u_sdl_checker (.clk, .rst_n, .transmit_select_n,
    .receive_select_n, .load_strobe, .lock_detect, .txActive_q, .rxActive_q, .txModData_q,
    .refDivider_q, .progDivider_q, .swallowDivider_q, .lock_out_select_q, .pulseWidthErr_q,
    .loadInTxErr_q);

/* sim/sdl_host_model.sv */
// host controller model shifting divider words into the synthesizer
`timescale 1ns/1ps
module sdl_host_model (
    input  logic clk,
    output logic serialClk,
    output logic serialData,
    output logic load_strobe
);
    // serial clock idles low between frames, strobe low while shifting
    initial begin
        serialClk = 1'b0;
        serialData = 1'b0;
        load_strobe = 1'b0;
    end
    // operation bits lead the divider; charge pump and lock select sent as 0
    function automatic logic [18:0] refWord(input logic pre, input logic [13:0] r);
        return {pre, 1'b0, 1'b0, 1'b1, r, 1'b1};
    endfunction
    function automatic logic [18:0] progWord(input logic [10:0] n, input logic [6:0] a);
        return {n, a, 1'b0};
    endfunction
    // msb first, target bit last; each serial clock level held two cycles, each data bit four
    task automatic send(input logic [18:0] w);
        int i;
        for (i = 18; i >= 0; i--) begin
            @(negedge clk);
            serialData = w[i];
            serialClk = 1'b0;
            repeat (2) @(negedge clk);
            serialClk = 1'b1;
            @(negedge clk);
        end
        @(negedge clk);
        serialClk = 1'b0;
        serialData = ~w[0]; // stale bit inverted so it cannot pass for data
        load_strobe = 1'b1;
        repeat (2) @(negedge clk);
        load_strobe = 1'b0;
    endtask
endmodule // sdl_host_model

/* sim/tb.sv */
// self-checking bench for the synthesizer serial load block
`timescale 1ns/1ps
module tb;
    localparam int LOCK = 20;
    logic        clk, rst_n, transmit_select_n_n, receive_select_n_n, txData;
    wire         sClk, sData, lStrobe, lock, txAct, rxAct, txMod;
    wire  [13:0] refDiv;
    wire  [10:0] progDiv;
    wire  [6:0]  swDiv;
    wire         pre128, cpHigh, lock_out_select, phase, pwErr, ltErr;
    int          bad_count = 0;
    int          n_compared = 0;
    logic        pwSeen = 1'b0;
    logic        ltSeen = 1'b0;

    sdl_serial_load #(.LOCK_CYCLES(LOCK), .PULSE_MIN_CYC(5), .PULSE_MAX_CYC(40)) u_sdl_serial_load (
        .clk(clk), .rst_n(rst_n), .transmit_select_n(transmit_select_n_n), .receive_select_n(receive_select_n_n),
        .serialClk(sClk), .serialData(sData), .load_strobe(lStrobe), .tx_data_in(txData),
        .lock_detect(lock), .txActive_q(txAct), .rxActive_q(rxAct), .txModData_q(txMod),
        .refDivider_q(refDiv), .progDivider_q(progDiv), .swallowDivider_q(swDiv),
        .prescaler128_q(pre128), .chargePumpHigh_q(cpHigh), .lock_out_select_q(lock_out_select),
        .phasePolarity_q(phase), .pulseWidthErr_q(pwErr), .loadInTxErr_q(ltErr));
    sdl_host_model u_sdl_host_model (.clk(clk), .serialClk(sClk), .serialData(sData),
        .load_strobe(lStrobe));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // error flags are one-cycle pulses, so latch them for the scenarios
    always @(posedge clk) begin
        if (pwErr === 1'b1) pwSeen <= 1'b1;
        if (ltErr === 1'b1) ltSeen <= 1'b1;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("mismatches %0d of %0d compared", bad_count, n_compared);
        if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic load(input logic [18:0] w);
        u_sdl_host_model.send(w);
        repeat (3) @(negedge clk);
    endtask

    task automatic sc_reset;
        check({refDiv, progDiv, swDiv}, {14'h0003, 11'h003, 7'h00});
        check({phase, lock, txAct, rxAct}, 4'h8);
    endtask
    task automatic sc_selects;
        int i;
        // i = 0 drives both selects low on purpose, which a host never should
        for (i = 0; i < 4; i++) begin
            {transmit_select_n_n, receive_select_n_n} = i[1:0];
            repeat (2) @(negedge clk);
            check(txAct, i == 1);
            check(rxAct, i == 2);
        end
    endtask
    task automatic sc_ref;
        logic pinWas;
        load(u_sdl_host_model.refWord(1'b1, 14'h3fff));
        check({pre128, refDiv}, {1'b1, 14'h3fff});
        check({cpHigh, lock_out_select, phase}, 3'h1);
        // lock select set: the shared pin toggles every R clocks instead of showing lock
        load({4'h3, 14'h0004, 1'b1});
        check({lock_out_select, refDiv}, {1'b1, 14'h0004});
        pinWas = lock;
        repeat (4) @(negedge clk);
        check(lock, !pinWas);
        repeat (4) @(negedge clk);
        check(lock, pinWas);
        load(u_sdl_host_model.refWord(1'b0, 14'h06a4));
        check({pre128, refDiv}, {1'b0, 14'h06a4});
        check(lock_out_select, 1'b0);
    endtask
    task automatic sc_prog(input logic [10:0] n, input logic [6:0] a, input logic expLock);
        load(u_sdl_host_model.progWord(n, a));
        check({progDiv, swDiv, lock}, {n, a, 1'b0});
        repeat (LOCK + 10) @(negedge clk);
        check(lock, expLock);
    endtask
    task automatic sc_tx;
        transmit_select_n_n = 1'b0;
        receive_select_n_n = 1'b1;
        repeat (10) @(negedge clk);
        txData = 1'b1;
        repeat (2) @(negedge clk);
        check(txMod, 1'b1);
        @(negedge clk);
        txData = 1'b0; // high run of three cycles is too short
        repeat (4) @(negedge clk);
        check(pwSeen, 1'b1);
        // low level held past the maximum pulses the flag once, 41 clocks after the falling edge
        repeat (36) @(negedge clk);
        check(pwErr, 1'b0);
        @(negedge clk);
        check(pwErr, 1'b1);
        @(negedge clk);
        check(pwErr, 1'b0);
        load(u_sdl_host_model.progWord(11'h221, 7'h18));
        check(ltSeen, 1'b1);
        transmit_select_n_n = 1'b1;
        receive_select_n_n = 1'b0;
        txData = 1'b1;
        repeat (3) @(negedge clk);
        check(txMod, 1'b0);
    endtask

    initial begin
        rst_n = 1'b0;
        transmit_select_n_n = 1'b1;
        receive_select_n_n = 1'b1;
        txData = 1'b0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        sc_reset;
        sc_selects;
        receive_select_n_n = 1'b0;
        sc_ref;
        // table entry: (channel - offset) / step, split by 64 into 545 and 24
        sc_prog(11'h221, 7'h18, 1'b1);
        sc_prog(11'h005, 7'h05, 1'b0);
        sc_prog(11'h7ff, 7'h7f, 1'b1);
        sc_prog(11'h003, 7'h02, 1'b1);
        sc_tx;
        final_report;
    end
    // whole run is under a thousand cycles
    initial begin
        #100000;
        bad_count++;
        final_report;
    end
endmodule // tb
